/* File: logic/ufb_pkg.sv */
package ufb_pkg;
  // ************************************************************
  // register map and field positions
  // ************************************************************
  localparam logic [7:0] OFF_FRAME = 8'h00;
  localparam logic [7:0] OFF_DIV_HI = 8'h04;
  localparam logic [7:0] OFF_DIV_LO = 8'h08;
  localparam logic [7:0] OFF_CTRL_B = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_TX = 8'h14;
  localparam logic [7:0] OFF_RX = 8'h18;
  localparam logic [7:0] FRAME_RST = 8'h06;
  localparam logic [3:0] DIV_HI_RST = 4'h0;
  localparam logic [7:0] DIV_LO_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_B_MASK = 8'h1c;
  localparam int FRM_POL = 0;
  localparam int FRM_CSZ = 1;
  localparam int FRM_STOP = 3;
  localparam int FRM_MODE = 6;
  localparam int CB_CSZ_TOP = 2;
  localparam int CB_TX_EN = 3;
  localparam int CB_RX_EN = 4;
  localparam int ST_DBL = 1;
  localparam int ST_FERR = 4;
  localparam int ST_TXBUSY = 6;
  localparam int ST_RXFULL = 7;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // baud timing: oversample factor minus one, and half of it
  // ************************************************************
  localparam logic [3:0] FAC_NORM_M1 = 4'hf;
  localparam logic [3:0] FAC_DBL_M1 = 4'h7;
  localparam logic [3:0] HALF_NORM_M1 = 4'h7;
  localparam logic [3:0] HALF_DBL_M1 = 4'h3;

  // reserved codes fall back to eight bits
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    unique case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction
endpackage

/* File: logic/ufb_baud_gen.sv */
`timescale 1ns/1ns
module ufb_baud_gen import ufb_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic load,
  input wire logic double_speed,
  input wire logic sync_mode,
  output logic os_tick,
  output logic bit_tick,
  output logic xck,
  output logic xck_rise,
  output logic xck_fall
);
  if (DIV_W < 1 || DIV_W > 16) begin : g_check
    $error("divisor width out of range");
  end

  logic [DIV_W-1:0] cnt_r;
  logic [3:0] fac_r;
  wire logic [3:0] fac_m1 = (double_speed && !sync_mode) ? FAC_DBL_M1 : FAC_NORM_M1;
  wire logic cnt_zero = (cnt_r == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      os_tick <= 1'b0;
    end else begin
      cnt_r <= (load || cnt_zero) ? divisor : cnt_r - 1'b1;
      os_tick <= cnt_zero && !load;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fac_r <= FAC_NORM_M1;
      bit_tick <= 1'b0;
    end else begin
      if (load) begin
        fac_r <= fac_m1;
      end else if (os_tick) begin
        fac_r <= (fac_r == 4'h0) ? fac_m1 : fac_r - 4'h1;
      end
      bit_tick <= os_tick && fac_r == 4'h0 && !sync_mode && !load;
    end
  end

  // synchronous clock: half period is one prescaler period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xck <= 1'b0;
      xck_rise <= 1'b0;
      xck_fall <= 1'b0;
    end else begin
      xck <= sync_mode && (os_tick ? !xck : xck);
      xck_rise <= sync_mode && os_tick && !xck;
      xck_fall <= sync_mode && os_tick && xck;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_div_reload: assert property (load |=> cnt_r == $past(divisor))
    else $error("prescaler not reloaded by divisor write");
  a_os_period: assert property (os_tick |-> $past(cnt_r) == '0 && !$past(load))
    else $error("prescaler tick without terminal count");
  a_factor_sel: assert property (os_tick && fac_r == 4'h0 && !load && !sync_mode
    |=> fac_r == ($past(double_speed) ? FAC_DBL_M1 : FAC_NORM_M1))
    else $error("wrong oversample factor");
endmodule

/* File: logic/ufb_tx_shift.sv */
`timescale 1ns/1ns
module ufb_tx_shift import ufb_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [8:0] data,
  input wire logic [3:0] nbits,
  input wire logic two_stop,
  input wire logic tick,
  output logic txd,
  output logic busy
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ufb_tx_e;
  ufb_tx_e state_r;
  logic [11:0] sh_r;
  logic [3:0] rem_r;

  // unused upper data bits are forced high so they merge into the stop bits
  wire logic [8:0] keep_mask = ~(9'h1ff << nbits);
  wire logic [11:0] frame_load = {2'h3, data | ~keep_mask, 1'b0};
  wire logic [3:0] frame_len = 4'h1 + nbits + (two_stop ? 4'h2 : 4'h1);

  assign busy = (state_r == TX_SEND);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= TX_IDLE;
      sh_r <= 12'hfff;
      rem_r <= 4'h0;
      txd <= 1'b1;
    end else begin
      unique case (state_r)
        TX_IDLE: begin
          if (start) begin
            sh_r <= frame_load;
            rem_r <= frame_len;
            state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tick && rem_r == 4'h0) begin
            state_r <= TX_IDLE;
          end else if (tick) begin
            txd <= sh_r[0];
            sh_r <= {1'b1, sh_r[11:1]};
            rem_r <= rem_r - 4'h1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_load;
    start && state_r == TX_IDLE ##1 state_r == TX_SEND;
  endsequence

  a_frame_len: assert property (s_load |-> rem_r == $past(frame_len, 1))
    else $error("frame length does not match stop setting");
  a_char_len: assert property (s_load |-> rem_r == 4'h1 + $past(nbits) + ($past(two_stop) ? 4'h2 : 4'h1))
    else $error("frame length does not match character size");
  a_stop_level: assert property (state_r == TX_SEND && rem_r <= 4'h1 && !start |-> sh_r[0] && (rem_r != 4'h0 || txd))
    else $error("stop bit not high");
  a_tx_on_tick: assert property (!tick |=> $stable(txd))
    else $error("serial output changed without a bit edge");
endmodule

/* File: logic/ufb_top.sv */
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Operation
// - transmitter sends one or two stop bits
// - receiver ignores the stop-bit select
// - three-bit code sets five to nine bits
// - polarity picks output-change and sample edges
// - divisor is twelve bits, high nibble plus byte
// - low byte write reloads the prescaler at once
// - double speed halves the oversample factor
module ufb_top import ufb_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic sync_serial_clock
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_check
    $error("address width out of range");
  end

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } ufb_rx_e;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    // a shift rather than a part-select keeps the default eight-bit address legal
    is_mapped = ((a >> 8) == '0) && (a[7:0] <= OFF_RX) && (a[1:0] == 2'h0);
  endfunction

  // ************************************************************
  // bus slave
  // ************************************************************
  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r, rd_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_word;
  logic w_strb0_r;
  logic [1:0] bresp_r, rresp_r;

  wire logic aw_fire = s_axi_awvalid && awready_r;
  wire logic w_fire = s_axi_wvalid && wready_r;
  wire logic b_fire = bvalid_r && s_axi_bready;
  wire logic ar_fire = s_axi_arvalid && arready_r;
  wire logic do_write = aw_full_r && w_full_r && !bvalid_r;
  wire logic aw_full_nxt = aw_fire || (aw_full_r && !b_fire);
  wire logic w_full_nxt = w_fire || (w_full_r && !b_fire);
  wire logic bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);
  wire logic rvalid_nxt = ar_fire || (rvalid_r && !s_axi_rready);
  wire logic wr_ok = do_write && w_strb0_r && is_mapped(aw_addr_r);

  wire logic wr_frame = wr_ok && aw_addr_r[7:0] == OFF_FRAME;
  wire logic wr_hi = wr_ok && aw_addr_r[7:0] == OFF_DIV_HI;
  wire logic wr_lo = wr_ok && aw_addr_r[7:0] == OFF_DIV_LO;
  wire logic wr_ctrl = wr_ok && aw_addr_r[7:0] == OFF_CTRL_B;
  wire logic wr_stat = wr_ok && aw_addr_r[7:0] == OFF_STAT;
  wire logic wr_tx = wr_ok && aw_addr_r[7:0] == OFF_TX;
  wire logic rd_rx = ar_fire && s_axi_araddr == ADDR_W'(OFF_RX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r <= !w_full_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_strb0_r <= 1'b0;
    end else begin
      if (aw_fire) aw_addr_r <= s_axi_awaddr;
      if (w_fire) w_data_r <= s_axi_wdata;
      if (w_fire) w_strb0_r <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
      rd_addr_r <= '0;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_fire) begin
        rdata_r <= rd_word;
        rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rd_addr_r <= s_axi_araddr;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] frame_r, div_lo_r, ctrl_b_r;
  logic [3:0] div_hi_r;
  logic dbl_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_r <= FRAME_RST;
      div_hi_r <= DIV_HI_RST;
      div_lo_r <= DIV_LO_RST;
      ctrl_b_r <= CTRL_B_RST;
      dbl_r <= 1'b0;
    end else begin
      if (wr_frame) frame_r <= w_data_r[7:0];
      if (wr_hi) div_hi_r <= w_data_r[3:0];
      if (wr_lo) div_lo_r <= w_data_r[7:0];
      if (wr_ctrl) ctrl_b_r <= w_data_r[7:0] & CTRL_B_MASK;
      if (wr_stat) dbl_r <= w_data_r[ST_DBL];
    end
  end

  wire logic sync_mode = frame_r[FRM_MODE+1:FRM_MODE] == MODE_SYNC;
  wire logic pol = frame_r[FRM_POL];
  wire logic two_stop = frame_r[FRM_STOP];
  wire logic tx_en = ctrl_b_r[CB_TX_EN];
  wire logic rx_en = ctrl_b_r[CB_RX_EN];
  wire logic [3:0] nbits = char_bits({ctrl_b_r[CB_CSZ_TOP], frame_r[FRM_CSZ+1:FRM_CSZ]});
  // the new low byte is handed over in the same cycle the reload fires
  wire logic [11:0] divisor = {div_hi_r, wr_lo ? w_data_r[7:0] : div_lo_r};

  // ************************************************************
  // baud generation and transmitter
  // ************************************************************
  logic os_tick, bit_tick, xck, xck_rise, xck_fall, tx_busy, txd;

  ufb_baud_gen #(.DIV_W(12)) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .divisor(divisor),
    .load(wr_lo),
    .double_speed(dbl_r),
    .sync_mode(sync_mode),
    .os_tick(os_tick),
    .bit_tick(bit_tick),
    .xck(xck),
    .xck_rise(xck_rise),
    .xck_fall(xck_fall)
  );

  wire logic tx_tick = sync_mode ? (pol ? xck_fall : xck_rise) : bit_tick;
  wire logic rx_edge = pol ? xck_rise : xck_fall;

  ufb_tx_shift u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wr_tx && tx_en && !tx_busy),
    .data(w_data_r[8:0]),
    .nbits(nbits),
    .two_stop(two_stop),
    .tick(tx_tick),
    .txd(txd),
    .busy(tx_busy)
  );

  assign serial_out_pin = txd;
  assign sync_serial_clock = xck;

  // ************************************************************
  // receiver
  // ************************************************************
  logic rxd_s1, rxd_s2, rxd_s3, rxd_q;
  ufb_rx_e rx_state_r;
  logic [3:0] rcnt_r, rx_idx_r;
  logic [8:0] rsh_r, rx_data_r;
  logic rx_full_r, ferr_r;

  // a change is believed once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_s3 <= 1'b1;
      rxd_q <= 1'b1;
    end else begin
      rxd_s1 <= serial_in_pin;
      rxd_s2 <= rxd_s1;
      rxd_s3 <= rxd_s2;
      if (rxd_s2 == rxd_s3) rxd_q <= rxd_s3;
    end
  end

  wire logic dbl_eff = dbl_r && !sync_mode;
  wire logic [3:0] fac_m1 = dbl_eff ? FAC_DBL_M1 : FAC_NORM_M1;
  wire logic [3:0] half_m1 = dbl_eff ? HALF_DBL_M1 : HALF_NORM_M1;
  wire logic rx_adv = sync_mode ? rx_edge : (os_tick && rcnt_r == 4'h0);
  wire logic rx_go = rx_en && !rxd_q && (sync_mode ? rx_edge : os_tick);
  wire logic rx_set = rx_state_r == RX_STOP && rx_adv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcnt_r <= HALF_NORM_M1;
    end else if (rx_state_r == RX_IDLE) begin
      rcnt_r <= half_m1;
    end else if (os_tick) begin
      rcnt_r <= (rcnt_r == 4'h0) ? fac_m1 : rcnt_r - 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_state_r <= RX_IDLE;
      rx_idx_r <= 4'h0;
      rsh_r <= 9'h0;
    end else begin
      unique case (rx_state_r)
        RX_IDLE: begin
          if (rx_go) rx_state_r <= sync_mode ? RX_DATA : RX_START;
          rx_idx_r <= 4'h0;
          rsh_r <= 9'h0;
        end
        RX_START: begin
          // a start bit gone high at mid-bit was a glitch
          if (rx_adv) rx_state_r <= rxd_q ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rx_adv) begin
            rsh_r[rx_idx_r] <= rxd_q;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == nbits - 4'h1) rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_adv) rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // a frame landing in the cycle its flag is read still raises the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_r <= 1'b0;
      ferr_r <= 1'b0;
      rx_data_r <= 9'h0;
    end else begin
      rx_full_r <= rx_set || (rx_full_r && !rd_rx);
      if (rx_set) begin
        rx_data_r <= rsh_r;
        ferr_r <= !rxd_q;
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] status_w;
  always_comb begin
    status_w = 8'h00;
    status_w[ST_DBL] = dbl_r;
    status_w[ST_FERR] = ferr_r;
    status_w[ST_TXBUSY] = tx_busy;
    status_w[ST_RXFULL] = rx_full_r;
  end

  wire logic [7:0] ra = s_axi_araddr[7:0];
  assign rd_word = !is_mapped(s_axi_araddr) ? 32'h0 :
                   ra == OFF_FRAME ? {24'h0, frame_r} :
                   ra == OFF_DIV_HI ? {28'h0, div_hi_r} :
                   ra == OFF_DIV_LO ? {24'h0, div_lo_r} :
                   ra == OFF_CTRL_B ? {24'h0, ctrl_b_r} :
                   ra == OFF_STAT ? {24'h0, status_w} :
                   ra == OFF_RX ? {23'h0, rx_data_r} : 32'h0;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_one_stop: assert property (rx_set |=> rx_state_r == RX_IDLE)
    else $error("receiver waited for a second stop bit");
  a_rx_width: assert property (rx_state_r == RX_STOP |-> rx_idx_r == nbits)
    else $error("receiver bit count does not match size");
  a_rx_sync_edge: assert property (sync_mode && rx_state_r == RX_DATA && !rx_edge |=> $stable(rx_idx_r))
    else $error("receiver sampled on the wrong edge");
  a_div_hi_read: assert property (rvalid_r && rresp_r == RESP_OKAY && rd_addr_r[7:0] == OFF_DIV_HI
    |-> rdata_r[31:4] == 28'h0)
    else $error("reserved divisor bits read nonzero");
  a_rx_set_wins: assert property (rx_set |=> rx_full_r)
    else $error("received frame lost");
  a_write_resp: assert property (do_write |=> bvalid_r)
    else $error("write response missing");
endmodule

/* File: testbench/ufb_serial_peer.sv */
`timescale 1ns/1ns
// ************************************************************
// remote serial peer: frame receiver and sender
// ************************************************************
module ufb_serial_peer (
  input wire logic aclk,
  input wire logic line_in,
  input wire logic sclk,
  output logic line_out
);
  initial line_out = 1'b1;

  // sample on falling edge for polarity 0, rising for 1
  task automatic sedge(input logic pol);
    if (pol) @(posedge sclk);
    else @(negedge sclk);
  endtask

  // drive on the opposite edge, so data is stable when sampled
  task automatic cedge(input logic pol);
    if (pol) @(negedge sclk);
    else @(posedge sclk);
  endtask

  // async: p is the bit period in clocks; sync: p unused, bits follow sclk
  task automatic recv(input int nb, input int p, input int lim, input logic sy, input logic pol,
                      output logic [8:0] d, output logic ok);
    int n;
    d = '0;
    n = 0;
    while (line_in && n < lim) begin
      if (sy) sedge(pol);
      else @(posedge aclk);
      n++;
    end
    ok = !line_in;
    if (!sy) repeat (p / 2) @(posedge aclk);
    ok = ok && !line_in;
    for (int i = 0; i < nb; i++) begin
      if (sy) sedge(pol);
      else repeat (p) @(posedge aclk);
      d[i] = line_in; // lsb first
    end
    if (sy) sedge(pol);
    else repeat (p) @(posedge aclk);
    ok = ok && line_in;
  endtask

  task automatic send(input int nb, input int p, input logic sy, input logic pol,
                      input logic [8:0] d, input logic stp);
    logic [10:0] f;
    f = 11'h7ff;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    f[nb+1] = stp;
    for (int i = 0; i < nb + 2; i++) begin
      if (sy) cedge(pol);
      else @(posedge aclk);
      line_out <= f[i];
      if (!sy) repeat (p - 1) @(posedge aclk);
    end
    if (sy) cedge(pol);
    else @(posedge aclk);
    // released line rests at its idle high level
    line_out <= 1'b1;
  endtask
endmodule

/* File: testbench/ufb_top_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module ufb_top_tb_top import ufb_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] resp;} ufb_row_s;
  typedef struct {logic [2:0] cs; logic stp; logic [11:0] dv; logic dbl; int nb; int p;} ufb_tx_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, sclk, ok;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [8:0] d;
  int mismatches = 0, checks = 0;
  ufb_row_s rows[7] = '{
    '{OFF_FRAME, 32'h3e, 32'h3e, RESP_OKAY},
    '{OFF_DIV_HI, 32'hff, 32'h0f, RESP_OKAY},
    '{OFF_DIV_LO, 32'h1a5, 32'ha5, RESP_OKAY},
    '{OFF_CTRL_B, 32'hff, 32'h1c, RESP_OKAY},
    '{OFF_STAT, 32'h02, 32'h02, RESP_OKAY},
    '{8'h1c, 32'h5a, 32'h00, RESP_SLVERR},
    '{8'h06, 32'h5a, 32'h00, RESP_SLVERR}};
  // first row leaves a large divisor running, so the next row needs the reload
  ufb_tx_s txr[6] = '{'{3'h0, 1'b0, 12'h100, 1'b1, 5, 2056}, '{3'h1, 1'b1, 12'h003, 1'b0, 6, 64},
    '{3'h2, 1'b0, 12'h003, 1'b0, 7, 64}, '{3'h3, 1'b1, 12'h003, 1'b0, 8, 64},
    '{3'h7, 1'b0, 12'h000, 1'b0, 9, 16}, '{3'h4, 1'b1, 12'h003, 1'b0, 8, 64}};
  logic [7:0] ra[4] = '{OFF_FRAME, OFF_DIV_HI, OFF_DIV_LO, OFF_CTRL_B};
  logic [7:0] re[4] = '{FRAME_RST, 8'h00, DIV_LO_RST, CTRL_B_RST};

  always #20 aclk = ~aclk;

  ufb_top ufb_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .serial_in_pin(rxd),
    .serial_out_pin(txd), .sync_serial_clock(sclk));
  ufb_serial_peer ufb_serial_peer_inst (.aclk(aclk), .line_in(txd), .sclk(sclk), .line_out(rxd));

  // ************************************************************
  // bus tasks: entered just after a rising edge
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dt;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cfg(input logic [1:0] md, input logic pol, input logic stp, input logic [2:0] cs,
                     input logic [11:0] dv, input logic dbl);
    wr(OFF_FRAME, {24'h0, md, 2'b00, stp, cs[1:0], pol}, r);
    wr(OFF_CTRL_B, {27'h0, 2'b11, cs[2], 2'b00}, r);
    wr(OFF_STAT, {30'h0, dbl, 1'b0}, r);
    wr(OFF_DIV_HI, {28'h0, dv[11:8]}, r); // upper bits written as zero
    wr(OFF_DIV_LO, {24'h0, dv[7:0]}, r); // high part first, low write reloads
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #(60000 * 40);
    mismatches++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, r);
      `CHK("wresp", rows[i].resp, r)
      rd(rows[i].a, v, r);
      `CHK("rdata", rows[i].e, v)
      `CHK("rresp", rows[i].resp, r)
    end
    $display("test registers done");
    // mid-run reset brings the frame, divisor and control registers back
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ra[i]) begin
      rd(ra[i], v, r);
      `CHK("reset value", {24'h0, re[i]}, v)
    end
    // a write with lane zero switched off is answered but leaves the register alone
    wstrb <= 4'h0;
    wr(OFF_FRAME, 32'h3e, r);
    wstrb <= 4'hf;
    `CHK("masked wresp", RESP_OKAY, r)
    rd(OFF_FRAME, v, r);
    `CHK("masked write", {24'h0, FRAME_RST}, v)
    $display("test reset done");
    foreach (txr[i]) begin
      cfg(2'b00, 1'b0, txr[i].stp, txr[i].cs, txr[i].dv, txr[i].dbl); // polarity zero when async
      wr(OFF_TX, 32'h1a5, r);
      ufb_serial_peer_inst.recv(txr[i].nb, txr[i].p, 2 * txr[i].p + 40, 1'b0, 1'b0, d, ok);
      `CHK("tx data", 9'h1a5 & ((9'h1 << txr[i].nb) - 9'h1), d)
      `CHK("tx timing", 1'b1, ok)
      repeat (txr[i].p - 4) @(posedge aclk);
      rd(OFF_STAT, v, r);
      `CHK("busy in second stop", txr[i].stp, v[ST_TXBUSY])
      // line quiet before the divisor changes
      repeat (2 * txr[i].p) @(posedge aclk);
      $display("test tx row %0d done", i);
    end
    cfg(2'b00, 1'b0, 1'b1, 3'h7, 12'h003, 1'b0);
    ufb_serial_peer_inst.send(9, 64, 1'b0, 1'b0, 9'h0b6, 1'b1);
    repeat (8) @(posedge aclk);
    rd(OFF_STAT, v, r);
    `CHK("rx stop ok", 1'b0, v[ST_FERR])
    `CHK("rx full", 1'b1, v[ST_RXFULL])
    rd(OFF_RX, v, r);
    `CHK("rx data", 9'h0b6, v[8:0])
    $display("test rx async done");
    for (int p = 0; p < 2; p++) begin
      cfg(MODE_SYNC, p[0], 1'b0, 3'h3, 12'h007, 1'b0);
      wr(OFF_TX, 32'h096, r);
      ufb_serial_peer_inst.recv(8, 0, 400, 1'b1, p[0], d, ok);
      `CHK("sync tx data", 9'h096, d)
      `CHK("sync tx frame", 1'b1, ok)
      @(posedge aclk);
      repeat (40) @(posedge aclk);
      ufb_serial_peer_inst.send(8, 0, 1'b1, p[0], 9'h069, 1'b1);
      @(posedge aclk);
      repeat (40) @(posedge aclk);
      rd(OFF_RX, v, r);
      `CHK("sync rx data", 9'h069, v[8:0])
      $display("test sync polarity %0d done", p);
    end
    conclude;
  end
endmodule
